// File: burst_cfg_pkg.sv
// Package with mode register map, field layouts, reset values and burst encodings.
// Functional notes
// - Burst length field bits 2:0 selects 4, 8 or 16 beats; four by default.
// - Burst type bit 3 selects sequential when 0 (default), interleaved when 1.
// - Wrap bit 4 selects wrap when 0 (default); no-wrap only with four beats.
// - Write-recovery bits 7:5 encode 3 to 8 cycles before auto-precharge starts.
// - Latency bits 3:0 select read/write latency pairs 3/1 through 8/4; others reserved.
// - Four-beat wrapping bursts use column bits 1:0, order 0123 or 2301.
// - Eight-beat bursts wrap; sequential counts up modulo 8, interleaved XORs start.
// - Sixteen-beat bursts count up modulo 16, sequential wrapping only.
// - Lowest column bit is absent from the bus and is taken as zero.
// - Mode reads of these write-only registers toggle strobe with undefined data.
package burst_cfg_pkg;
	localparam logic [7:0] ADDR_BURST_CFG   = 8'h01;
	localparam logic [7:0] ADDR_LATENCY_CFG = 8'h02;
	localparam int LEN_LSB        = 0;
	localparam int ORDER_TYPE_BIT = 3;
	localparam int WRAP_CTRL_BIT  = 4;
	localparam int WR_LSB  = 5;
	localparam int LAT_LSB = 0;
	localparam logic [2:0] LEN_CODE_4  = 3'h2;
	localparam logic [2:0] LEN_CODE_8  = 3'h3;
	localparam logic [2:0] LEN_CODE_16 = 3'h4;
	localparam logic [2:0] WR_CODE_MIN = 3'h1;
	localparam logic [2:0] WR_CODE_MAX = 3'h6;
	localparam logic [3:0] WR_CYC_OFFSET = 4'h2;
	localparam logic [7:0] BURST_CFG_RESET   = 8'h22;
	localparam logic [7:0] LATENCY_CFG_RESET = 8'h01;
	localparam logic [3:0] READ_LAT_TABLE [0:6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
	localparam logic [3:0] WRITE_LAT_TABLE [0:6] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4};
	localparam logic [3:0] LAT_CODE_MAX = 4'h6;
	localparam int MR_READ_BEATS = 4;
	typedef enum logic [1:0] {
		LEN4_TYPE,
		LEN8_TYPE,
		LEN16_TYPE
	} burst_len_type;
	typedef enum {
		IDLE_ST,
		RUN_ST
	} burst_state_type;
endpackage

// File: burst_cfg_if.sv
// Interface carrying the decoded burst configuration between modules.
`timescale 1ns/1ns
interface burst_cfg_if;
	import burst_cfg_pkg::*;
	burst_len_type len;
	logic          interleaved;
	logic          no_wrap;
	logic          cfg_illegal;
	modport src (output len, output interleaved, output no_wrap, output cfg_illegal);
	modport dst (input len, input interleaved, input no_wrap, input cfg_illegal);
endinterface : burst_cfg_if

// File: burst_cfg_regs.sv
// Write-only mode registers and decode of burst, recovery and latency fields.
`timescale 1ns/1ns
module burst_cfg_regs
	import burst_cfg_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_data,
	burst_cfg_if.src        cfg,
	output logic [3:0]      o_wr_cycles,
	output logic [3:0]      o_read_lat,
	output logic [3:0]      o_write_lat,
	output logic            o_lat_illegal
);
	logic [7:0] burst_and_write_recovery_config;
	logic [7:0] read_write_latency_config;
	logic [2:0] len_code;
	logic [2:0] wr_code;
	logic [3:0] lat_code;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			burst_and_write_recovery_config <= BURST_CFG_RESET;
		end else if (i_wr && i_addr == ADDR_BURST_CFG) begin
			burst_and_write_recovery_config <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			read_write_latency_config <= LATENCY_CFG_RESET;
		end else if (i_wr && i_addr == ADDR_LATENCY_CFG) begin
			read_write_latency_config <= i_data;
		end
	end

	assign len_code = burst_and_write_recovery_config[LEN_LSB +: 3];
	assign wr_code  = burst_and_write_recovery_config[WR_LSB +: 3];
	assign lat_code = read_write_latency_config[LAT_LSB +: 4];

	always_comb begin
		cfg.len = LEN4_TYPE;
		unique case (len_code)
			LEN_CODE_8:  cfg.len = LEN8_TYPE;
			LEN_CODE_16: cfg.len = LEN16_TYPE;
			default:    cfg.len = LEN4_TYPE;
		endcase
	end

	assign cfg.interleaved = burst_and_write_recovery_config[ORDER_TYPE_BIT];
	assign cfg.no_wrap     = burst_and_write_recovery_config[WRAP_CTRL_BIT];
	// Unsupported combinations wrap downstream, interleaved only at eight beats; an unknown length code gives four beats, no-wrap if bit 4 is set.
	assign cfg.cfg_illegal = (len_code != LEN_CODE_4 && len_code != LEN_CODE_8
		&& len_code != LEN_CODE_16)
		|| (cfg.no_wrap && len_code != LEN_CODE_4)
		|| (cfg.interleaved && len_code == LEN_CODE_16)
		|| wr_code < WR_CODE_MIN || wr_code > WR_CODE_MAX;

	assign o_wr_cycles = {1'b0, wr_code} + WR_CYC_OFFSET;
	assign o_lat_illegal = lat_code == 4'h0 || lat_code > LAT_CODE_MAX;
	assign o_read_lat  = o_lat_illegal ? 4'h0 : READ_LAT_TABLE[lat_code[2:0]];
	assign o_write_lat = o_lat_illegal ? 4'h0 : WRITE_LAT_TABLE[lat_code[2:0]];
endmodule : burst_cfg_regs

// File: burst_order_gen.sv
// Column order generator: one column address per beat of a burst.
`timescale 1ns/1ns
module burst_order_gen
	import burst_cfg_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_start,
	input  wire logic [9:0] i_col,
	burst_cfg_if.dst        cfg,
	output logic            o_valid,
	output logic            o_last,
	output logic [9:0]      o_col
);
	burst_state_type state;
	logic [9:0] base;
	logic [3:0] beat;
	logic [3:0] last_beat;
	burst_len_type len;
	logic          inter;
	logic          nowrap;
	logic          next_inter;
	logic          next_nowrap;
	logic          start_ok;

	// Column of beat n of a burst; the output register loads it one beat early and holds it during beat n.
	function automatic logic [9:0] beat_col(
		input logic [9:0]    b,
		input logic [3:0]    n,
		input burst_len_type l,
		input logic          il,
		input logic          nw
	);
		logic [3:0] off;
		logic [9:0] col;
		off = il ? (n ^ b[3:0]) : (n + b[3:0]);
		col = b;
		if (nw) begin
			col = b + {6'h00, n};
		end else begin
			unique case (l)
				LEN8_TYPE:  col = {b[9:3], off[2:0]};
				LEN16_TYPE: col = {b[9:4], off};
				default:    col = {b[9:2], off[1:0]};
			endcase
		end
		return col;
	endfunction

	assign start_ok    = i_start && (state == IDLE_ST || beat == last_beat);
	assign next_inter  = cfg.interleaved && cfg.len == LEN8_TYPE;
	assign next_nowrap = cfg.no_wrap && cfg.len == LEN4_TYPE;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= IDLE_ST;
			beat  <= 4'h0;
		end else begin
			unique case (state)
				IDLE_ST: if (i_start) begin
					state <= RUN_ST;
					beat  <= 4'h0;
				end
				RUN_ST: begin
					if (beat == last_beat && !i_start) begin
						state <= IDLE_ST;
					end
					beat <= (beat == last_beat) ? 4'h0 : beat + 4'h1;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			base   <= 10'h000;
			len    <= LEN4_TYPE;
			inter  <= 1'b0;
			nowrap <= 1'b0;
		end else if (start_ok) begin
			base   <= {i_col[9:1], 1'b0};
			len    <= cfg.len;
			inter  <= next_inter;
			nowrap <= next_nowrap;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_col <= 10'h000;
		end else if (start_ok) begin
			o_col <= beat_col({i_col[9:1], 1'b0}, 4'h0, cfg.len, next_inter, next_nowrap);
		end else if (state == RUN_ST) begin
			o_col <= beat_col(base, beat + 4'h1, len, inter, nowrap);
		end
	end

	always_comb begin
		unique case (len)
			LEN8_TYPE:  last_beat = 4'h7;
			LEN16_TYPE: last_beat = 4'hF;
			default:    last_beat = 4'h3;
		endcase
	end

	assign o_valid = state == RUN_ST;
	assign o_last  = o_valid && beat == last_beat;
endmodule : burst_order_gen

// File: burst_mode_config_and_order.sv
// Top: reset sync, mode register write/read handling and burst column ordering.
`timescale 1ns/1ns
module burst_mode_config_and_order
	import burst_cfg_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_mode_reg_write_cmd,
	input  wire logic       i_mode_reg_read_cmd,
	input  wire logic [7:0] i_mr_addr,
	input  wire logic [7:0] i_mr_data,
	input  wire logic       i_col_cmd,
	input  wire logic [9:0] i_cmd_addr_bus_col,
	output logic            o_beat_valid,
	output logic            o_beat_last,
	output logic [9:0]      o_beat_col,
	output logic [3:0]      o_write_recovery_cycles,
	output logic [3:0]      o_read_latency,
	output logic [3:0]      o_write_latency,
	output logic            o_cfg_illegal,
	output logic            o_strobe,
	output logic            o_strobe_oe_n,
	output logic [7:0]      o_mr_rdata
);
	logic       rst_meta;
	logic       rst_n;
	logic       lat_illegal;
	logic [2:0] rd_cnt;
	logic       rd_active;
	logic [3:0] wr_cyc;
	logic [3:0] read_lat;
	logic [3:0] write_lat;

	burst_cfg_if cfg_bus ();

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	burst_cfg_regs u_regs (
		.i_clk         (i_clk),
		.i_rstn        (rst_n),
		.i_wr          (i_mode_reg_write_cmd),
		.i_addr        (i_mr_addr),
		.i_data        (i_mr_data),
		.cfg           (cfg_bus.src),
		.o_wr_cycles   (wr_cyc),
		.o_read_lat    (read_lat),
		.o_write_lat   (write_lat),
		.o_lat_illegal (lat_illegal)
	);

	burst_order_gen u_order (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_start (i_col_cmd),
		.i_col   (i_cmd_addr_bus_col),
		.cfg     (cfg_bus.dst),
		.o_valid (o_beat_valid),
		.o_last  (o_beat_last),
		.o_col   (o_beat_col)
	);

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_write_recovery_cycles <= 4'h3;
			o_read_latency          <= 4'h3;
			o_write_latency         <= 4'h1;
			o_cfg_illegal           <= 1'b0;
		end else begin
			o_write_recovery_cycles <= wr_cyc;
			o_read_latency          <= read_lat;
			o_write_latency         <= write_lat;
			o_cfg_illegal           <= cfg_bus.cfg_illegal || lat_illegal;
		end
	end

	// A read of a write-only register still drives the strobe for a short burst.
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_cnt   <= 3'h0;
			o_strobe <= 1'b0;
		end else if (rd_cnt != 3'h0) begin
			rd_cnt   <= rd_cnt - 3'h1;
			o_strobe <= ~o_strobe;
		end else begin
			o_strobe <= 1'b0;
			if (i_mode_reg_read_cmd) begin
				rd_cnt <= 3'(MR_READ_BEATS);
			end
		end
	end

	assign rd_active     = rd_cnt != 3'h0;
	assign o_strobe_oe_n = ~rd_active;
	// Returned data is undefined by design; zero is a safe concrete value.
	assign o_mr_rdata    = 8'h00;
endmodule : burst_mode_config_and_order

// File: burst_mode_config_and_order_properties.sv
// Checker of burst ordering, register decode and strobe behaviour at the top ports.
`timescale 1ns/1ns
module burst_mode_props (
	input wire logic       i_clk,
	input wire logic       i_rstn,
	input wire logic       i_mode_reg_write_cmd,
	input wire logic       i_mode_reg_read_cmd,
	input wire logic [7:0] i_mr_addr,
	input wire logic [7:0] i_mr_data,
	input wire logic       i_col_cmd,
	input wire logic [9:0] i_cmd_addr_bus_col,
	input wire logic       o_beat_valid,
	input wire logic       o_beat_last,
	input wire logic [9:0] o_beat_col,
	input wire logic [3:0] o_write_recovery_cycles,
	input wire logic [3:0] o_read_latency,
	input wire logic [3:0] o_write_latency,
	input wire logic       o_strobe,
	input wire logic       o_strobe_oe_n
);
	logic [4:0] run;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) run <= 5'h0;
		else run <= o_beat_valid ? run + 5'h1 : 5'h0;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	a_strobe_window_len: assert property (i_mode_reg_read_cmd && o_strobe_oe_n |=>
		!o_strobe_oe_n [*4] ##1 o_strobe_oe_n) else $error("strobe window length wrong");
	a_strobe_bit_toggles: assert property (!o_strobe_oe_n && !$past(o_strobe_oe_n) |->
		o_strobe != $past(o_strobe)) else $error("strobe did not toggle");
	a_latency_code_six: assert property (i_mode_reg_write_cmd && i_mr_addr == 8'h02 &&
		i_mr_data[3:0] == 4'h6 |-> ##2 o_read_latency == 4'h8 && o_write_latency == 4'h4)
		else $error("latency decode wrong");
	a_recovery_code_one: assert property (i_mode_reg_write_cmd && i_mr_addr == 8'h01 &&
		i_mr_data[7:5] == 3'h1 |-> ##2 o_write_recovery_cycles == 4'h3)
		else $error("recovery decode wrong");
	a_first_beat_col: assert property (i_col_cmd && !o_beat_valid |=> o_beat_valid &&
		o_beat_col == {$past(i_cmd_addr_bus_col[9:1]), 1'b0}) else $error("first column wrong");
	a_beat_parity_alt: assert property (o_beat_valid && !o_beat_last |=> o_beat_valid &&
		o_beat_col[0] != $past(o_beat_col[0])) else $error("beat sequence broken");
	a_run_len_mult4: assert property ($fell(o_beat_valid) |-> run[1:0] == 2'h0)
		else $error("burst length not a multiple of four");
	a_last_ends_burst: assert property (o_beat_last && !i_col_cmd |=> !o_beat_valid)
		else $error("burst ran past its last beat");
endmodule // burst_mode_props
bind burst_mode_config_and_order burst_mode_props i_burst_mode_props (
	.i_clk                   (i_clk),
	.i_rstn                  (i_rstn),
	.i_mode_reg_write_cmd    (i_mode_reg_write_cmd),
	.i_mode_reg_read_cmd     (i_mode_reg_read_cmd),
	.i_mr_addr               (i_mr_addr),
	.i_mr_data               (i_mr_data),
	.i_col_cmd               (i_col_cmd),
	.i_cmd_addr_bus_col      (i_cmd_addr_bus_col),
	.o_beat_valid            (o_beat_valid),
	.o_beat_last             (o_beat_last),
	.o_beat_col              (o_beat_col),
	.o_write_recovery_cycles (o_write_recovery_cycles),
	.o_read_latency          (o_read_latency),
	.o_write_latency         (o_write_latency),
	.o_strobe                (o_strobe),
	.o_strobe_oe_n           (o_strobe_oe_n)
);

// File: mem_ctrl_model.sv
// Memory controller model issuing mode register and column commands.
`timescale 1ns/1ns
module mem_ctrl_model (
	input  wire logic i_clk,
	output logic      o_wr,
	output logic      o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_data,
	output logic      o_col,
	output logic [9:0] o_col_addr
);
	initial begin
		{o_wr, o_rd, o_col, o_addr, o_data, o_col_addr} = '0;
	end
	// Recovery code from the recovery time and clock period, rounded up to whole cycles.
	function automatic logic [2:0] recovery_code(input int write_recovery_time,
		input int clk_period);
		return 3'((write_recovery_time + clk_period - 1) / clk_period - 2);
	endfunction
	task automatic mode_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_data <= (a == 8'h02) ? {4'h0, d[3:0]} : d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_data <= ~d;
	endtask
	task automatic mode_read();
		@(posedge i_clk);
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
	endtask
	task automatic col(input logic [9:0] c);
		@(posedge i_clk);
		o_col <= 1'b1;
		o_col_addr <= c;
		@(posedge i_clk);
		o_col <= 1'b0;
		o_col_addr <= ~c;
	endtask
endmodule // mem_ctrl_model

// File: test_burst_mode_config_and_order.sv
// Self-checking testbench for burst configuration and column ordering.
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module test_burst_mode_config_and_order;
	logic i_clk, i_rstn, i_mode_reg_write_cmd, i_mode_reg_read_cmd, i_col_cmd;
	logic o_beat_valid, o_beat_last, o_cfg_illegal, o_strobe, o_strobe_oe_n;
	logic [7:0] i_mr_addr, i_mr_data, o_mr_rdata;
	logic [9:0] i_cmd_addr_bus_col, o_beat_col;
	logic [3:0] o_write_recovery_cycles, o_read_latency, o_write_latency;
	int mismatches, num_checks, seed = 32'h01848A7F;
	int rlt[7] = '{0, 3, 4, 5, 6, 7, 8};
	int wlt[7] = '{0, 1, 2, 2, 3, 4, 4};
	logic [7:0] cfgs[6] = '{8'h22, 8'h4A, 8'h63, 8'h8B, 8'hA4, 8'hD2};
	logic [9:0] q[$];
	burst_mode_config_and_order i_burst_mode_config_and_order (
		.i_clk                   (i_clk),
		.i_rstn                  (i_rstn),
		.i_mode_reg_write_cmd    (i_mode_reg_write_cmd),
		.i_mode_reg_read_cmd     (i_mode_reg_read_cmd),
		.i_mr_addr               (i_mr_addr),
		.i_mr_data               (i_mr_data),
		.i_col_cmd               (i_col_cmd),
		.i_cmd_addr_bus_col      (i_cmd_addr_bus_col),
		.o_beat_valid            (o_beat_valid),
		.o_beat_last             (o_beat_last),
		.o_beat_col              (o_beat_col),
		.o_write_recovery_cycles (o_write_recovery_cycles),
		.o_read_latency          (o_read_latency),
		.o_write_latency         (o_write_latency),
		.o_cfg_illegal           (o_cfg_illegal),
		.o_strobe                (o_strobe),
		.o_strobe_oe_n           (o_strobe_oe_n),
		.o_mr_rdata              (o_mr_rdata)
	);
	mem_ctrl_model i_mem_ctrl_model (.i_clk(i_clk), .o_wr(i_mode_reg_write_cmd),
		.o_rd(i_mode_reg_read_cmd), .o_addr(i_mr_addr), .o_data(i_mr_data),
		.o_col(i_col_cmd), .o_col_addr(i_cmd_addr_bus_col));
	function automatic logic [9:0] ecol(int s, int i, int n_beats, int ilv, int nw);
		s = s & 'h3FE;
		if (nw) return 10'(s + i);
		if (ilv) return 10'((s & ~(n_beats - 1)) | ((s ^ i) & (n_beats - 1)));
		return 10'((s & ~(n_beats - 1)) | ((s + i) & (n_beats - 1)));
	endfunction
	task automatic results();
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	initial begin
		#500000;
		mismatches++;
		results();
	end
	// Each beat is checked against the queued model order.
	always @(posedge i_clk) begin
		if (o_beat_valid === 1'b1 && q.size() > 0) begin
			`CHK(o_beat_col, q[0])
			`CHK(o_beat_last, q.size() == 1)
			void'(q.pop_front());
		end else `CHK(o_beat_valid, 1'b0)
	end
	initial begin
		int s, blen, k;
		i_rstn = 1'b0;
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		`CHK({o_read_latency, o_write_latency}, 8'h31)
		`CHK(o_write_recovery_cycles, 4'h3)
		for (int c = 1; c <= 6; c++) begin
			i_mem_ctrl_model.mode_write(8'h02, 8'(c));
			i_mem_ctrl_model.mode_write(8'h03, 8'h05);
			repeat (2) @(posedge i_clk);
			#1;
			`CHK({o_read_latency, o_write_latency}, {4'(rlt[c]), 4'(wlt[c])})
		end
		foreach (cfgs[n]) begin
			i_mem_ctrl_model.mode_write(8'h01, cfgs[n]);
			repeat (2) @(posedge i_clk);
			#1;
			`CHK(o_write_recovery_cycles, 4'(cfgs[n][7:5] + 2))
			`CHK(o_cfg_illegal, 1'b0)
			blen = 4 << (cfgs[n][2:0] - 2);
			repeat (3) begin
				s = cfgs[n][4] ? 'h010 | ($random(seed) & 'h3EC) : $random(seed) & 'h3FF;
				for (k = 0; k < blen; k++) q.push_back(ecol(s, k, blen, cfgs[n][3], cfgs[n][4]));
				i_mem_ctrl_model.col(10'(s));
				for (k = 0; k < 40 && q.size() > 0; k++) @(posedge i_clk);
				`CHK(q.size(), 0)
			end
		end
		// A recovery time of 450 ns at a 100 ns clock rounds up to five cycles.
		i_mem_ctrl_model.mode_write(8'h01, {i_mem_ctrl_model.recovery_code(450, 100), 5'h02});
		repeat (2) @(posedge i_clk);
		#1;
		`CHK(o_write_recovery_cycles, 4'h5)
		i_mem_ctrl_model.mode_write(8'h01, 8'h33);
		repeat (2) @(posedge i_clk);
		#1;
		`CHK(o_cfg_illegal, 1'b1)
		i_mem_ctrl_model.mode_read();
		for (k = 0; k < 4; k++) begin
			#1;
			`CHK({o_strobe_oe_n, o_strobe}, {1'b0, k[0]})
			`CHK(o_mr_rdata, 8'h00)
			@(posedge i_clk);
		end
		#1;
		`CHK(o_strobe_oe_n, 1'b1)
		results();
	end
endmodule // test_burst_mode_config_and_order
